// File: dbg_map.svh
/*
  Register offsets, field positions and reset values of the debug break
  and trace unit. Assumes byte addresses on a 32-bit Avalon-MM slave.
*/
`ifndef DBG_MAP_SVH
`define DBG_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL     6'h00
`define OFS_STATUS   6'h04
`define OFS_MASK     6'h08
`define OFS_CH1ADDR  6'h0C
`define OFS_CH1DATA  6'h10
`define OFS_CH1CFG   6'h14
`define OFS_CH2ADDR  6'h18
`define OFS_CH2CFG   6'h1C
`define OFS_CH3CFG   6'h20
`define OFS_RESUME   6'h24
`define OFS_TRSTAT   6'h28

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_TRACE_EN 0
`define CTRL_NONRT    1
`define CTRL_STOP     2
`define CTRL_BRK1     3
`define CTRL_BRK2     4
`define CTRL_BRK3     5
`define ST_BRK1       0
`define ST_BRK2       1
`define ST_BRK3       2
`define ST_DROP       3
`define ST_FULL       4
`define ST_W          5
`define CFG_ADDRESS_SPACE_IDENTIFIER_EN   8
`define CFG_ADDR_EN   9
`define CFG_DATA_EN   10
`define CFG_SIZE_LO   11
`define CFG_RW_LO     13
`define CFG_KIND_LO   15
`define CFG_CNT_LO    20
`define CH3_IO_EN     0
`define CH3_TRANSLATION_TABLE_LOAD_INSTRUCTION_EN  1
`define TRS_FULL      16
`define TRS_WRAP      17

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define RST_CTRL      32'h0000_0000
`define RST_CFG       32'h0001_8000
`define NIBBLES       3'h7

`endif

// File: dbg_pkg.sv
/*
  Types shared by the debug break and trace unit modules.
  Assumes dbg_map.svh is compiled alongside.
*/
package dbg_pkg;

  typedef enum logic [1:0] {
    TRC_IDLE = 2'b00,
    TRC_SYNC = 2'b01,
    TRC_DATA = 2'b11
  } trc_state_t;

  // Bus kind selector: 3 means any bus
  typedef enum logic [1:0] {
    KIND_LALL  = 2'h0,
    KIND_LDATA = 2'h1,
    KIND_IBUS  = 2'h2,
    KIND_ANY   = 2'h3
  } bus_kind_t;

  typedef enum logic [1:0] {
    RW_ANY   = 2'h0,
    RW_READ  = 2'h1,
    RW_WRITE = 2'h2
  } rw_sel_t;

  function automatic logic dataMatch(input logic [31:0] a,
                                     input logic [31:0] b,
                                     input logic [1:0]  sz);
    unique case (sz)
      2'h0:    dataMatch = (a[7:0] == b[7:0]);
      2'h1:    dataMatch = (a[15:0] == b[15:0]);
      default: dataMatch = (a == b);
    endcase
  endfunction

endpackage

// File: dbg_if.sv
/*
  Carrier between the top of the debug unit and its leaf modules:
  observed bus cycle and trace output hand-off.
*/
`timescale 1ns/1ps
`default_nettype none
interface dbg_if;
  logic        obsValid;
  logic [31:0] obsAddr;
  logic [31:0] obsPc;
  logic [31:0] obsData;
  logic [7:0]  obsAsid;
  logic        obsRead;
  logic [1:0]  obsSize;
  logic [1:0]  obsKind;
  logic        trcStart;
  logic [31:0] trcWord;
  logic        trcBusy;
  modport brk (input obsValid, obsAddr, obsPc, obsData, obsAsid,
               obsRead, obsSize, obsKind);
  modport trc (input trcStart, trcWord, output trcBusy);
  modport ctl (output obsValid, obsAddr, obsPc, obsData, obsAsid,
               obsRead, obsSize, obsKind, trcStart, trcWord,
               input trcBusy);
endinterface
`default_nettype wire

// File: break_channel.sv
/*
  One break condition channel with address, identifier, bus state and,
  where built, data and count conditions.
  Assumes a synchronous observed bus and registered configuration.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbg_map.svh"
module break_channel import dbg_pkg::*; #(
  parameter bit HAS_DATA  = 1'b1,
  parameter bit HAS_COUNT = 1'b1,
  parameter int CNT_W     = 12
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  dbg_if.brk               obs,
  input  wire logic        enable,
  input  wire logic [31:0] addrVal,
  input  wire logic [31:0] dataVal,
  input  wire logic [31:0] cfg,
  output logic             hit
);
  if (CNT_W < 1 || CNT_W > 12) begin : g_chk
    $error("CNT_W out of range");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             hit;
  } ch_state_t;
  ch_state_t s_r, s_nxt;

  logic             cond;
  logic [CNT_W-1:0] target;
  rw_sel_t          rw;
  bus_kind_t        kind;

  always_comb begin
    rw     = rw_sel_t'(cfg[`CFG_RW_LO +: 2]);
    kind   = bus_kind_t'(cfg[`CFG_KIND_LO +: 2]);
    target = HAS_COUNT ? cfg[`CFG_CNT_LO +: CNT_W] : '0;
    cond = enable && obs.obsValid;
    if (cfg[`CFG_ADDR_EN] && obs.obsAddr != addrVal &&
        obs.obsPc != addrVal) begin
      cond = 1'b0;
    end
    if (HAS_DATA && cfg[`CFG_DATA_EN] &&
        !dataMatch(obs.obsData, dataVal,
                   cfg[`CFG_SIZE_LO +: 2])) begin
      cond = 1'b0;
    end
    if (cfg[`CFG_ADDRESS_SPACE_IDENTIFIER_EN] && obs.obsAsid != cfg[7:0]) begin
      cond = 1'b0;
    end
    if ((rw == RW_READ && !obs.obsRead) ||
        (rw == RW_WRITE && obs.obsRead)) begin
      cond = 1'b0;
    end
    if (kind != KIND_ANY && kind != bus_kind_t'(obs.obsKind)) begin
      cond = 1'b0;
    end
    s_nxt     = s_r;
    s_nxt.hit = 1'b0;
    if (!enable) begin
      s_nxt.cnt = '0;
    end else if (cond) begin
      if (target == '0 || s_r.cnt + 1'b1 == target) begin
        s_nxt.hit = 1'b1;
        s_nxt.cnt = '0;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hit = s_r.hit;
endmodule
`default_nettype wire

// File: trace_port.sv
/*
  Trace output serialiser: a sync strobe, then eight nibbles of one
  32-bit branch word, least significant first.
  Assumes the caller starts it only while not busy.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbg_map.svh"
module trace_port import dbg_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       nrst,
  dbg_if.trc              link,
  output logic [3:0]      tData,
  output logic            tSyncN
);
  typedef struct packed {
    trc_state_t  st;
    logic [31:0] word;
    logic [2:0]  nib;
    logic [3:0]  data;
    logic        syncN;
  } tp_state_t;
  tp_state_t s_r, s_nxt;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.syncN = 1'b1;
    unique case (s_r.st)
      TRC_IDLE: begin
        if (link.trcStart) begin
          s_nxt.word  = link.trcWord;
          s_nxt.syncN = 1'b0;
          s_nxt.nib   = '0;
          s_nxt.st    = TRC_SYNC;
        end
      end
      TRC_SYNC: begin
        s_nxt.data = s_r.word[3:0];
        s_nxt.word = s_r.word >> 4;
        s_nxt.st   = TRC_DATA;
      end
      TRC_DATA: begin
        if (s_r.nib == `NIBBLES) begin
          s_nxt.st = TRC_IDLE;
        end else begin
          s_nxt.data = s_r.word[3:0];
          s_nxt.word = s_r.word >> 4;
          s_nxt.nib  = s_r.nib + 3'h1;
        end
      end
      default: s_nxt.st = TRC_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_r <= '{st: TRC_IDLE, word: '0, nib: '0, data: '0, syncN: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.trcBusy = (s_r.st != TRC_IDLE);
  assign tData        = s_r.data;
  assign tSyncN       = s_r.syncN;
endmodule
`default_nettype wire

// File: debug_break_trace_unit.sv
/*
  Debug break and trace unit top: three break channels, halt control,
  branch trace with selectable overrun and buffer-full policies, and an
  Avalon-MM register slave with a masked interrupt.
  Assumes all inputs synchronous to mclk; the CPU holds a branch while
  cpuStall is high.
*/
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dbg_map.svh"
module debug_break_trace_unit import dbg_pkg::*; #(
  parameter int TRACE_DEPTH = 256
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Avalon-MM slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             irq,
  // Observed CPU bus
  input  wire logic        busValid,
  input  wire logic [31:0] busAddr,
  input  wire logic [31:0] busPc,
  input  wire logic [31:0] busData,
  input  wire logic [7:0]  busAsid,
  input  wire logic        busRead,
  input  wire logic [1:0]  busSize,
  input  wire logic [1:0]  busKind,
  input  wire logic        busIo,
  input  wire logic        execLdtlb,
  // Branch events
  input  wire logic        branchValid,
  input  wire logic [31:0] branchSrc,
  output logic             cpuStall,
  output logic             cpuHalt,
  // Trace pins, shared with a general-purpose port
  input  wire logic [4:0]  gpioOut,
  input  wire logic [4:0]  gpioOe,
  output logic [4:0]       gpioIn,
  input  wire logic [4:0]  pinIn,
  output logic [4:0]       pinOut,
  output logic [4:0]       pinOe
);
  if (TRACE_DEPTH < 1 || TRACE_DEPTH > 65535) begin : g_chk
    $error("TRACE_DEPTH out of range");
  end

  localparam logic [15:0] DEPTH16 = 16'(TRACE_DEPTH);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0]       ctrl;
    logic [`ST_W-1:0]  status;
    logic [`ST_W-1:0]  mask;
    logic [31:0]       ch1Addr;
    logic [31:0]       ch1Data;
    logic [31:0]       ch1Cfg;
    logic [31:0]       ch2Addr;
    logic [31:0]       ch2Cfg;
    logic [1:0]        ch3Cfg;
    logic              halt;
    logic [15:0]       trCnt;
    logic              trFull;
    logic              trWrap;
    logic              ack;
    logic [31:0]       rdata;
  } top_state_t;
  top_state_t s_r, s_nxt;

  dbg_if lnk ();

  logic       hit1;
  logic       hit2;
  logic       hit3;
  logic       trOn;
  logic       take;
  logic       rec;
  logic [3:0] tData;
  logic       tSyncN;
  logic       rdAck;
  logic       wrAck;
  logic [`ST_W-1:0] ev;

  // ----------------------------------------
  // Observed bus into the channels
  // ----------------------------------------
  assign lnk.obsValid = busValid;
  assign lnk.obsAddr  = busAddr;
  assign lnk.obsPc    = busPc;
  assign lnk.obsData  = busData;
  assign lnk.obsAsid  = busAsid;
  assign lnk.obsRead  = busRead;
  assign lnk.obsSize  = busSize;
  assign lnk.obsKind  = busKind;

  // Channel 1 carries every break_channel condition class; peripheral and table-load breaks are channel 3 only
  break_channel #(
    .HAS_DATA  (1'b1),
    .HAS_COUNT (1'b1),
    .CNT_W     (12)
  ) u_ch1 (
    .mclk    (mclk),
    .nrst    (nrst),
    .obs     (lnk.brk),
    .enable  (s_r.ctrl[`CTRL_BRK1]),
    .addrVal (s_r.ch1Addr),
    .dataVal (s_r.ch1Data),
    .cfg     (s_r.ch1Cfg),
    .hit     (hit1)
  );

  // Channel 2 is built without data and count logic at all
  break_channel #(
    .HAS_DATA  (1'b0),
    .HAS_COUNT (1'b0),
    .CNT_W     (1)
  ) u_ch2 (
    .mclk    (mclk),
    .nrst    (nrst),
    .obs     (lnk.brk),
    .enable  (s_r.ctrl[`CTRL_BRK2]),
    .addrVal (s_r.ch2Addr),
    .dataVal ('0),
    .cfg     (s_r.ch2Cfg),
    .hit     (hit2)
  );

  // Channel 3 only sees peripheral accesses and table loads
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hit3 <= 1'b0;
    end else begin
      hit3 <= s_r.ctrl[`CTRL_BRK3] &&
              ((s_r.ch3Cfg[`CH3_IO_EN] && busValid && busIo) ||
               (s_r.ch3Cfg[`CH3_TRANSLATION_TABLE_LOAD_INSTRUCTION_EN] && execLdtlb));
    end
  end

  // ----------------------------------------
  // Trace output and pin sharing
  // ----------------------------------------
  trace_port u_tp (
    .mclk   (mclk),
    .nrst   (nrst),
    .link   (lnk.trc),
    .tData  (tData),
    .tSyncN (tSyncN)
  );

  assign trOn = s_r.ctrl[`CTRL_TRACE_EN];

  // Pins are given back to the port whenever trace is off
  always_comb begin
    if (trOn) begin
      pinOut = {tSyncN, tData};
      pinOe  = 5'h1F;
    end else begin
      pinOut = gpioOut;
      pinOe  = gpioOe;
    end
  end
  assign gpioIn = pinIn;

  // Overrun policy and full policy come from separate bits
  assign cpuStall = trOn && s_r.ctrl[`CTRL_NONRT] && branchValid &&
                    lnk.trcBusy;
  assign take = trOn && branchValid && !lnk.trcBusy;
  // Stop mode refuses new records once full; the CPU is not stalled
  assign rec  = take && !(s_r.ctrl[`CTRL_STOP] && s_r.trFull);
  assign lnk.trcStart = rec;
  assign lnk.trcWord  = branchSrc;

  // ----------------------------------------
  // Bus slave: one wait cycle, then answer
  // ----------------------------------------
  assign waitrequest = (read || write) && !s_r.ack;
  assign readdata    = s_r.rdata;
  assign rdAck       = read && s_r.ack;
  assign wrAck       = write && s_r.ack;
  assign irq         = |(s_r.status & s_r.mask);
  assign cpuHalt     = s_r.halt;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.ack = (read || write) && !s_r.ack;
    ev        = '0;
    ev[`ST_BRK1] = hit1;
    ev[`ST_BRK2] = hit2;
    ev[`ST_BRK3] = hit3;
    // Realtime mode loses the branch rather than stall
    ev[`ST_DROP] = trOn && !s_r.ctrl[`CTRL_NONRT] && branchValid &&
                   lnk.trcBusy;

    // Trace fill count
    if (rec) begin
      if (s_r.trCnt + 16'h1 == DEPTH16) begin
        s_nxt.trFull = 1'b1;
        ev[`ST_FULL] = 1'b1;
        s_nxt.trCnt  = s_r.ctrl[`CTRL_STOP] ? s_r.trCnt + 16'h1 : '0;
      end else begin
        s_nxt.trCnt = s_r.trCnt + 16'h1;
      end
      if (s_r.trFull && !s_r.ctrl[`CTRL_STOP]) begin
        s_nxt.trWrap = 1'b1;
      end
    end

    // Register writes, acted on at the answer edge
    if (wrAck) begin
      unique case (address)
        `OFS_CTRL:    s_nxt.ctrl    = writedata;
        `OFS_MASK:    s_nxt.mask    = writedata[`ST_W-1:0];
        `OFS_CH1ADDR: s_nxt.ch1Addr = writedata;
        `OFS_CH1DATA: s_nxt.ch1Data = writedata;
        `OFS_CH1CFG:  s_nxt.ch1Cfg  = writedata;
        `OFS_CH2ADDR: s_nxt.ch2Addr = writedata;
        `OFS_CH2CFG:  s_nxt.ch2Cfg  = writedata;
        `OFS_CH3CFG:  s_nxt.ch3Cfg  = writedata[1:0];
        `OFS_RESUME:  begin
          if (writedata[0]) begin
            s_nxt.halt = 1'b0;
          end
        end
        `OFS_TRSTAT:  begin
          // A fill event in the clearing cycle keeps the full flag
          s_nxt.trCnt  = '0;
          s_nxt.trFull = ev[`ST_FULL];
          s_nxt.trWrap = 1'b0;
        end
        default:      ;
      endcase
    end

    // Read data is latched on the wait cycle
    if (read && !s_r.ack) begin
      unique case (address)
        `OFS_CTRL:    s_nxt.rdata = s_r.ctrl;
        `OFS_STATUS:  s_nxt.rdata = 32'(s_r.status);
        `OFS_MASK:    s_nxt.rdata = 32'(s_r.mask);
        `OFS_CH1ADDR: s_nxt.rdata = s_r.ch1Addr;
        `OFS_CH1DATA: s_nxt.rdata = s_r.ch1Data;
        `OFS_CH1CFG:  s_nxt.rdata = s_r.ch1Cfg;
        `OFS_CH2ADDR: s_nxt.rdata = s_r.ch2Addr;
        `OFS_CH2CFG:  s_nxt.rdata = s_r.ch2Cfg;
        `OFS_CH3CFG:  s_nxt.rdata = 32'(s_r.ch3Cfg);
        `OFS_RESUME:  s_nxt.rdata = 32'(s_r.halt);
        `OFS_TRSTAT:  s_nxt.rdata = {14'h0, s_r.trWrap, s_r.trFull,
                                     s_r.trCnt};
        default:      s_nxt.rdata = '0;
      endcase
    end

    // Status clears on read; a same-cycle event still sets its bit
    if (rdAck && address == `OFS_STATUS) begin
      s_nxt.status = '0;
    end
    s_nxt.status = s_nxt.status | ev;

    // Any break hands control to the debug handler
    if (hit1 || hit2 || hit3) begin
      s_nxt.halt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_r        <= '0;
      s_r.ctrl   <= `RST_CTRL;
      s_r.ch1Cfg <= `RST_CFG;
      s_r.ch2Cfg <= `RST_CFG;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

// File: dbg_monitor.sv
/*
  Checker bound to the debug unit top; sees only its ports.
  Assumes the bus master holds each request until it is accepted.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbg_map.svh"
module dbg_monitor (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        busValid,
  input wire logic        execLdtlb,
  input wire logic        branchValid,
  input wire logic        cpuStall,
  input wire logic        cpuHalt,
  input wire logic [4:0]  gpioOut,
  input wire logic [4:0]  gpioOe,
  input wire logic [4:0]  gpioIn,
  input wire logic [4:0]  pinIn,
  input wire logic [4:0]  pinOut,
  input wire logic [4:0]  pinOe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  a_idle_nowait: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest without a request");
  a_rdata_hold: assert property (!read |=> $stable(readdata))
    else $error("read data changed without a read");
  a_halt_cause: assert property ($rose(cpuHalt) |->
    $past(busValid, 2) || $past(execLdtlb, 2))
    else $error("halt without a bus cycle two edges before");
  a_halt_holds: assert property (cpuHalt &&
    !(write && !waitrequest && address == `OFS_RESUME) |=> cpuHalt)
    else $error("halt released without a resume write");
  a_stall_cause: assert property (cpuStall |-> branchValid)
    else $error("stall without a pending branch");
  a_stall_bound: assert property ($rose(cpuStall) |-> ##[1:10] !cpuStall)
    else $error("stall outlived the trace output");
  a_sync_frame: assert property (pinOe[4] && !pinOut[4] |=> pinOut[4] [*8])
    else $error("trace frame cut short");
  a_pins_port: assert property (pinOe != 5'h1F |->
    pinOe == gpioOe && pinOut == gpioOut)
    else $error("pins not handed to the port function");
  a_gpio_in: assert property (gpioIn == pinIn)
    else $error("port input does not follow the pins");
endmodule
bind debug_break_trace_unit dbg_monitor mon (.mclk, .nrst, .address, .read,
  .write, .readdata, .waitrequest, .busValid, .execLdtlb, .branchValid,
  .cpuStall, .cpuHalt, .gpioOut, .gpioOe, .gpioIn, .pinIn, .pinOut, .pinOe);
`default_nettype wire

// File: trace_probe.sv
/*
  Emulator probe on the trace pins: resolves pin levels and collects
  each framed word. Assumes sync is active low on pin 4.
*/
`timescale 1ns/1ps
`default_nettype none
module trace_probe (
  input  wire logic [4:0]  pinOut,
  input  wire logic [4:0]  pinOe,
  input  wire logic        mclk,
  output logic      [4:0]  pinIn,
  output logic      [31:0] lastWord,
  output int               frames
);
  logic [31:0] sh   = 32'h0000_0000;
  logic [3:0]  left = 4'h0;
  logic        wob  = 1'b0;
  initial frames = 0;
  // Released pins float; a toggling level hides no stale value
  assign pinIn = (pinOe & pinOut) | (~pinOe & {5{wob}});
  always @(posedge mclk) begin
    wob <= !wob;
    if (pinOe[4] && !pinOut[4]) begin
      left <= 4'h8;
    end else if (left != 4'h0) begin
      sh <= {pinOut[3:0], sh[31:4]};
      left <= left - 4'h1;
      if (left == 4'h1) begin
        lastWord <= {pinOut[3:0], sh[31:4]};
        frames <= frames + 1;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
/*
  Self-checking bench for the debug break and trace unit.
  Assumes the probe model on the pins and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbg_map.svh"
module testbench import dbg_pkg::*;;
  localparam int DEPTH = 4;
  logic        mclk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
  logic        busValid = 1'b0, busRead = 1'b0, busIo = 1'b0;
  logic        execLdtlb = 1'b0, branchValid = 1'b0;
  logic        waitrequest, irq, cpuStall, cpuHalt;
  logic [5:0]  address = 6'h00;
  logic [31:0] writedata = 32'h0000_0000, busAddr = 32'h0000_0000;
  logic [31:0] busPc = 32'h0000_0000, busData = 32'h0000_0000;
  logic [31:0] branchSrc = 32'h0000_0000, readdata, lastWord, rv;
  logic [7:0]  busAsid = 8'h5A;
  logic [1:0]  busSize = 2'h2;
  logic [1:0]  busKind = KIND_LALL;
  logic [4:0]  gpioOut = 5'h15, gpioOe = 5'h0A, gpioIn, pinIn, pinOut, pinOe;
  int          frames, f, compares = 0, badCount = 0, stallCyc = 0;
  debug_break_trace_unit #(.TRACE_DEPTH(DEPTH)) dut (.mclk, .nrst, .address,
    .read, .write, .writedata, .readdata, .waitrequest, .irq, .busValid,
    .busAddr, .busPc, .busData, .busAsid, .busRead, .busSize, .busKind,
    .busIo, .execLdtlb, .branchValid, .branchSrc, .cpuStall, .cpuHalt,
    .gpioOut, .gpioOe, .gpioIn, .pinIn, .pinOut, .pinOe);
  trace_probe probe (.mclk, .pinOut, .pinOe, .pinIn, .lastWord, .frames);
  initial forever #2.5 mclk = ~mclk;
  // ------------------------------------------
  // Shared tasks
  // ------------------------------------------
  task automatic finishTest();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Waitrequest and read data are both taken at the answering edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    rv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdc(input string n, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(n, rv, e);
  endtask
  task automatic obs(input logic [31:0] a, pc, d, input logic io);
    busValid <= 1'b1;
    busAddr <= a;
    busPc <= pc;
    busData <= d;
    busIo <= io;
    @(posedge mclk);
    busValid <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic hit(input string n, input logic e, input logic [31:0] st);
    chk(n, cpuHalt, e);
    rdc(n, `OFS_STATUS, st);
    bus(1'b1, `OFS_RESUME, 32'h0000_0001);
    chk(n, {irq, cpuHalt}, 2'b00);
  endtask
  task automatic br(input logic [31:0] s);
    branchValid <= 1'b1;
    branchSrc <= s;
    do begin
      @(posedge mclk);
      stallCyc += (cpuStall === 1'b1);
    end while (cpuStall !== 1'b0);
    branchValid <= 1'b0;
    @(posedge mclk);
  endtask
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_regs();
    rdc("ctrl", `OFS_CTRL, `RST_CTRL);
    rdc("ch2cfg", `OFS_CH2CFG, `RST_CFG);
    bus(1'b1, `OFS_STATUS, 32'hFFFF_FFFF);
    rdc("status ro", `OFS_STATUS, 32'h0000_0000);
    bus(1'b1, 6'h3C, 32'h1234_5678);
    rdc("unmapped", 6'h3C, 32'h0000_0000);
    bus(1'b1, `OFS_MASK, 32'h0000_001F);
    rdc("mask", `OFS_MASK, 32'h0000_001F);
    $display("test regs done");
  endtask
  task automatic t_ch1();
    bus(1'b1, `OFS_CH1ADDR, 32'h0C00_1000);
    bus(1'b1, `OFS_CH1CFG, 32'h0021_8200);
    bus(1'b1, `OFS_CTRL, 32'h0000_0008);
    obs(32'h0000_0040, 32'h0C00_1000, 32'h0000_0000, 1'b0);
    hit("count one", 1'b0, 32'h0000_0000);
    obs(32'h0C00_1000, 32'h0000_0040, 32'h0000_0000, 1'b0);
    chk("irq", irq, 1'b1);
    hit("count two", 1'b1, 32'h0000_0001);
    bus(1'b1, `OFS_CH1DATA, 32'h0000_00A5);
    bus(1'b1, `OFS_CH1CFG, 32'h0001_8600);
    busSize <= 2'h0;
    obs(32'h0C00_1000, 32'h0000_0000, 32'hFFFF_FFA5, 1'b0);
    hit("byte data", 1'b1, 32'h0000_0001);
    bus(1'b1, `OFS_CH1CFG, 32'h0001_9600);
    busSize <= 2'h2;
    obs(32'h0C00_1000, 32'h0000_0000, 32'hFFFF_FFA5, 1'b0);
    hit("long data", 1'b0, 32'h0000_0000);
    $display("test channel one done");
  endtask
  task automatic t_ch23();
    busKind <= KIND_IBUS;
    bus(1'b1, `OFS_CH2ADDR, 32'h0000_2000);
    bus(1'b1, `OFS_CH2CFG, 32'h0031_475A);
    bus(1'b1, `OFS_CTRL, 32'h0000_0010);
    obs(32'h0000_2000, 32'h0000_0000, 32'hDEAD_BEEF, 1'b0);
    hit("ch2 plain", 1'b1, 32'h0000_0002);
    busKind <= KIND_LDATA;
    obs(32'h0000_2000, 32'h0000_0000, 32'hDEAD_BEEF, 1'b0);
    hit("ch2 kind", 1'b0, 32'h0000_0000);
    busKind <= KIND_IBUS;
    busRead <= 1'b1;
    obs(32'h0000_2000, 32'h0000_0000, 32'hDEAD_BEEF, 1'b0);
    hit("ch2 read", 1'b0, 32'h0000_0000);
    busRead <= 1'b0;
    bus(1'b1, `OFS_CH3CFG, 32'h0000_0002);
    bus(1'b1, `OFS_CTRL, 32'h0000_0020);
    obs(32'h0000_0100, 32'h0000_0000, 32'h0000_0000, 1'b1);
    hit("io off", 1'b0, 32'h0000_0000);
    execLdtlb <= 1'b1;
    @(posedge mclk);
    execLdtlb <= 1'b0;
    repeat (3) @(posedge mclk);
    hit("table load", 1'b1, 32'h0000_0004);
    bus(1'b1, `OFS_CH3CFG, 32'h0000_0001);
    obs(32'h0000_0100, 32'h0000_0000, 32'h0000_0000, 1'b1);
    hit("io on", 1'b1, 32'h0000_0004);
    $display("test channels two and three done");
  endtask
  task automatic t_overrun(input logic nonrt);
    bus(1'b1, `OFS_CTRL, {30'h0000_0000, nonrt, 1'b1});
    f = frames;
    stallCyc = 0;
    br(32'h1234_5678);
    br(32'h9ABC_DEF0);
    repeat (12) @(posedge mclk);
    chk("frames", frames, f + 1 + nonrt);
    chk("word", lastWord, nonrt ? 32'h9ABC_DEF0 : 32'h1234_5678);
    chk("stalled", stallCyc != 0, nonrt);
    rdc("drop", `OFS_STATUS, nonrt ? 32'h0000_0000 : 32'h0000_0008);
    $display("test overrun policy %0d done", nonrt);
  endtask
  task automatic t_full(input logic stop, input logic [31:0] ts);
    bus(1'b1, `OFS_TRSTAT, 32'h0000_0000);
    bus(1'b1, `OFS_CTRL, {29'h0000_0000, stop, !stop, 1'b1});
    bus(1'b0, `OFS_STATUS, 32'h0000_0000);
    f = frames;
    for (int i = 0; i < DEPTH + 1; i++) begin
      br(32'h0000_1000 + i);
      repeat (11) @(posedge mclk);
    end
    chk("full frames", frames, f + DEPTH + !stop);
    rdc("trstat", `OFS_TRSTAT, ts);
    rdc("full flag", `OFS_STATUS, 32'h0000_0010);
    $display("test buffer policy %0d done", stop);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_ch1();
    t_ch23();
    t_overrun(1'b0);
    t_overrun(1'b1);
    t_full(1'b1, 32'h0001_0004);
    t_full(1'b0, 32'h0003_0001);
    finishTest();
  end
  // Run is a few hundred cycles; this bound only cuts a hang
  initial begin
    repeat (20000) @(posedge mclk);
    badCount++;
    $display("watchdog expired");
    finishTest();
  end
endmodule
`default_nettype wire
